// File: inc/mbrd_pkg.sv
/*
 package for the register-map decoder: register numbers, data-type sizes,
 command codes, packed request/answer carriers.
 assumes a framing layer outside that delivers decoded register accesses.
*/
package mbrd_pkg;
    // data type sizes in registers
    localparam int unsigned REGS_TWO_REGISTER_FLOAT = 2;
    localparam int unsigned REGS_SINGLE_REGISTER_FLOAT = 1;
    localparam int unsigned REGS_UNSIGNED_WORD = 1;
    localparam int unsigned REGS_UNSIGNED_LONG = 2;
    localparam int unsigned REGS_PACKED_CHAR_PAIR = 1;
    // function codes
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h10;
    // exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_DEVICE = 8'h04;
    // message limits
    localparam logic [7:0] MAX_REGS_16 = 8'h7d;
    // register numbers (message address directly)
    localparam logic [15:0] REG_CMD = 16'h0046;
    localparam logic [15:0] REG_CMD_ARG = 16'h0047;
    localparam logic [15:0] REG_SYS_BASE = 16'h03e8;
    localparam logic [15:0] REG_NAME_BASE = 16'h00f0;
    localparam logic [15:0] REG_NAME_LAST = 16'h00f9;
    localparam logic [15:0] REG_FLOAT_BASE = 16'h1f40;
    localparam logic [15:0] REG_LONG_BASE = 16'h1f42;
    localparam logic [15:0] REG_FLOAT32_BASE = 16'h1b58;
    localparam logic [15:0] REG_CMD_RESET = 16'h0000;
    localparam logic [7:0] PAD_CHAR = 8'hff;
    localparam int unsigned NAME_REGS = 10;
    // configuration words served from register 1000 on
    localparam logic [15:0] SYS_REGS = 16'd18;
    // command codes
    localparam logic [15:0] CMD_POLL_ROLL = 16'd20000;
    localparam logic [15:0] CMD_CLR_ALL_TOT = 16'd30000;
    localparam logic [15:0] CMD_CLR_RUN1_TOT = 16'd30001;
    localparam logic [15:0] CMD_CLR_TURB1 = 16'd30003;
    localparam logic [15:0] CMD_CLR_TURB2 = 16'd30004;
    localparam logic [15:0] CMD_CLR_ALL_LATCH = 16'd30050;
    localparam logic [15:0] CMD_CLR_LATCH1 = 16'd30051;
    localparam logic [15:0] CMD_ADD_PULSES = 16'd30061;
    localparam logic [15:0] CMD_CLR_ALL_ALARM = 16'd30100;
    localparam logic [15:0] CMD_CLR_RUN_ALARM = 16'd30101;
    localparam logic [15:0] CMD_CLR_IN_ALARM = 16'd30102;
    localparam logic [15:0] CMD_DEFAULTS = 16'd40000;
    localparam logic [15:0] CMD_WATCHDOG = 16'd40040;
    localparam logic [15:0] CMD_PART_ARCHIVE = 16'd50050;

    // one register access from the framing layer
    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mbrd_req_t;

    // answer to one register access
    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
        logic [7:0] exc;
    } mbrd_rsp_t;

    // one-cycle function strobes toward the flow engine
    typedef struct packed {
        logic poll_roll;
        logic clr_all_tot;
        logic clr_run1_tot;
        logic clr_turb1;
        logic clr_turb2;
        logic clr_all_latch;
        logic clr_latch1;
        logic add_pulses;
        logic clr_all_alarm;
        logic clr_run_alarm;
        logic clr_in_alarm;
        logic load_defaults;
        logic watchdog_reset;
        logic part_archive;
    } mbrd_cmd_t;

    // all state of the decoder
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] cmd_arg;
        mbrd_rsp_t rsp;
        mbrd_cmd_t strobe;
        logic [15:0] pulse_count;
    } mbrd_state_t;
endpackage

// File: src/mbrd_decoder.sv
/*
 register-map front end: answers decoded register reads and writes,
 formats multi-register values, pads strings and decodes control commands.
 assumes a framing layer on mclk delivering one request per valid pulse,
 and data sources on mclk that stand stable while read.
*/
// What this block does
// RQ1 - fixed register counts per data type
// RQ2 - most significant word sits first
// RQ3 - unsigned word fits one register
// RQ4 - two chars per register, first high
// RQ5 - device name spans ten registers
// RQ6 - unused string characters read 0xff
// RQ7 - read-only refuse writes, read/write accept both
// RQ8 - blocks start at fixed register numbers
// RQ9 - register number equals message address
// RQ10 - control register decodes written command codes
// RQ11 - 20000 rolls polling totals over
// RQ12 - 30000 all totals, 30001 run one
// RQ13 - 30003/30004 clear turbine totals
// RQ14 - 30050 all latches, 30051 latch one
// RQ15 - 30061 adds second control register pulses
// RQ16 - 30100/30101/30102 clear alarm states
// RQ17 - defaults, watchdog reset, partial archive
// RQ18 - polling allowed only when unrestricted
// RQ19 - reads 03h, writes 10h only
// RQ20 - at most 125 registers per message
// RQ21 - unknown codes trigger nothing
// RQ22 - read-only writes refused with exception
`timescale 1ns/1ps
`default_nettype none
module mbrd_decoder (
    input wire logic mclk,
    input wire logic srst,
    input wire mbrd_pkg::mbrd_req_t req,
    input wire logic [7:0] req_count,
    input wire logic port_unrestricted,
    input wire logic [15:0] sys_words [0:17],
    input wire logic [7:0] name_chars [0:19],
    input wire logic [4:0] name_len,
    input wire logic [31:0] flow_float,
    input wire logic [31:0] flow_long,
    output mbrd_pkg::mbrd_rsp_t rsp,
    output mbrd_pkg::mbrd_cmd_t cmd_strobe,
    output logic [15:0] pulse_add_count
);
    // registered and next state
    mbrd_pkg::mbrd_state_t state_q;
    mbrd_pkg::mbrd_state_t state_d;
    // decode helpers
    logic is_read;
    logic is_write;
    logic [15:0] name_idx;
    logic [15:0] sys_idx;
    logic [4:0] char_hi;
    logic [4:0] char_lo;
    // message size inside the legal range
    logic ok_count;
    // an accepted write of the control register
    logic cmd_wr_ok;
    // an accepted read
    logic rd_ok;

    // all checks below run on mclk, quiet in reset
    default clocking cb_mclk @(posedge mclk);
    endclocking
    default disable iff (srst);

    // an accepted write of one command code
    sequence s_cmd(logic [15:0] code);
        cmd_wr_ok && (req.wdata == code);
    endsequence

    // an accepted read of one register
    sequence s_rd(logic [15:0] a);
        rd_ok && (req.addr == a);
    endsequence

    // request classification and index arithmetic
    always_comb begin
        // RQ19 - function code filter
        is_read = req.valid && (req.func == mbrd_pkg::FC_READ);
        is_write = req.valid && (req.func == mbrd_pkg::FC_WRITE);
        // RQ9 - address used as is
        name_idx = req.addr - mbrd_pkg::REG_NAME_BASE;
        sys_idx = req.addr - mbrd_pkg::REG_SYS_BASE;
        // RQ4 - earlier char in high byte
        // index kept at five bits so registers 8 and 9 reach chars 16..19
        char_hi = {name_idx[3:0], 1'b0};
        char_lo = {name_idx[3:0], 1'b1};
        // accepted accesses, for the checks below
        ok_count = (req_count != 8'h00) && (req_count <= mbrd_pkg::MAX_REGS_16);
        rd_ok = is_read && port_unrestricted && ok_count;
        cmd_wr_ok = is_write && port_unrestricted && ok_count &&
            (req.addr == mbrd_pkg::REG_CMD);
    end

    // next-state logic
    always_comb begin
        state_d = state_q;
        // strobes last one cycle
        state_d.strobe = '0;
        state_d.rsp = '0;
        if (req.valid) begin
            state_d.rsp.valid = 1'b1;
            state_d.rsp.exc = mbrd_pkg::EXC_NONE;
            if (!port_unrestricted) begin
                // RQ18 - restricted port refused
                state_d.rsp.exc = mbrd_pkg::EXC_DEVICE;
            end else if (!is_read && !is_write) begin
                state_d.rsp.exc = mbrd_pkg::EXC_FUNC;
            end else if (req_count > mbrd_pkg::MAX_REGS_16 || req_count == 8'h00) begin
                // RQ20 - message length limit
                state_d.rsp.exc = mbrd_pkg::EXC_ADDR;
            end else if (is_write) begin
                // RQ7 - only read/write registers store
                if (req.addr == mbrd_pkg::REG_CMD) begin
                    state_d.cmd = req.wdata;
                    // RQ10 - command decode on write
                    unique case (req.wdata)
                        // RQ11 - polling rollover
                        mbrd_pkg::CMD_POLL_ROLL: state_d.strobe.poll_roll = 1'b1;
                        // RQ12 - total clears
                        mbrd_pkg::CMD_CLR_ALL_TOT: state_d.strobe.clr_all_tot = 1'b1;
                        mbrd_pkg::CMD_CLR_RUN1_TOT: state_d.strobe.clr_run1_tot = 1'b1;
                        // RQ13 - turbine clears
                        mbrd_pkg::CMD_CLR_TURB1: state_d.strobe.clr_turb1 = 1'b1;
                        mbrd_pkg::CMD_CLR_TURB2: state_d.strobe.clr_turb2 = 1'b1;
                        // RQ14 - latch clears
                        mbrd_pkg::CMD_CLR_ALL_LATCH: state_d.strobe.clr_all_latch = 1'b1;
                        mbrd_pkg::CMD_CLR_LATCH1: state_d.strobe.clr_latch1 = 1'b1;
                        // RQ15 - pulse add with argument
                        mbrd_pkg::CMD_ADD_PULSES: begin
                            state_d.strobe.add_pulses = 1'b1;
                            state_d.pulse_count = state_q.cmd_arg;
                        end
                        // RQ16 - alarm clears
                        mbrd_pkg::CMD_CLR_ALL_ALARM: state_d.strobe.clr_all_alarm = 1'b1;
                        mbrd_pkg::CMD_CLR_RUN_ALARM: state_d.strobe.clr_run_alarm = 1'b1;
                        mbrd_pkg::CMD_CLR_IN_ALARM: state_d.strobe.clr_in_alarm = 1'b1;
                        // RQ17 - system functions
                        mbrd_pkg::CMD_DEFAULTS: state_d.strobe.load_defaults = 1'b1;
                        mbrd_pkg::CMD_WATCHDOG: state_d.strobe.watchdog_reset = 1'b1;
                        mbrd_pkg::CMD_PART_ARCHIVE: state_d.strobe.part_archive = 1'b1;
                        // RQ21 - unknown code stored, fires no strobe
                        default: state_d.strobe = '0;
                    endcase
                end else if (req.addr == mbrd_pkg::REG_CMD_ARG) begin
                    state_d.cmd_arg = req.wdata;
                end else begin
                    // RQ22 - read-only or unmapped write refused
                    state_d.rsp.exc = mbrd_pkg::EXC_ADDR;
                end
            end else begin
                // RQ8 - block decode by starting number
                if (req.addr == mbrd_pkg::REG_CMD) begin
                    // RQ3 - whole word in one register
                    state_d.rsp.rdata = state_q.cmd;
                end else if (req.addr == mbrd_pkg::REG_CMD_ARG) begin
                    state_d.rsp.rdata = state_q.cmd_arg;
                end else if (req.addr >= mbrd_pkg::REG_SYS_BASE &&
                             sys_idx < mbrd_pkg::SYS_REGS) begin
                    state_d.rsp.rdata = sys_words[sys_idx[4:0]];
                end else if (req.addr >= mbrd_pkg::REG_NAME_BASE &&
                             req.addr <= mbrd_pkg::REG_NAME_LAST) begin
                    // RQ5 - ten registers, twenty chars
                    // RQ6 - pad past string end
                    state_d.rsp.rdata[15:8] = (char_hi < name_len) ?
                        name_chars[char_hi] : mbrd_pkg::PAD_CHAR;
                    state_d.rsp.rdata[7:0] = (char_lo < name_len) ?
                        name_chars[char_lo] : mbrd_pkg::PAD_CHAR;
                end else if (req.addr == mbrd_pkg::REG_FLOAT_BASE) begin
                    // RQ2 - high word first
                    state_d.rsp.rdata = flow_float[31:16];
                end else if (req.addr == mbrd_pkg::REG_FLOAT_BASE + 16'h0001) begin
                    // RQ1 - two-register float low word
                    state_d.rsp.rdata = flow_float[15:0];
                end else if (req.addr == mbrd_pkg::REG_LONG_BASE) begin
                    state_d.rsp.rdata = flow_long[31:16];
                end else if (req.addr == mbrd_pkg::REG_LONG_BASE + 16'h0001) begin
                    state_d.rsp.rdata = flow_long[15:0];
                end else begin
                    state_d.rsp.exc = mbrd_pkg::EXC_ADDR;
                end
            end
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from flops
    assign rsp = state_q.rsp;
    assign cmd_strobe = state_q.strobe;
    assign pulse_add_count = state_q.pulse_count;

    // RQ10 - write to control register stored
    AST_CMD_STORE: assert property (@(posedge mclk) disable iff (srst) // RQ10
        (is_write && port_unrestricted && req_count == 8'h01 && req.addr == mbrd_pkg::REG_CMD)
        |=> (state_q.cmd == $past(req.wdata)))
        else $error("control register did not store write");
    // RQ12 - clear all totals strobe
    AST_CLR_TOT: assert property (@(posedge mclk) disable iff (srst) // RQ12
        (is_write && port_unrestricted && req_count == 8'h01 && req.addr == mbrd_pkg::REG_CMD
         && req.wdata == mbrd_pkg::CMD_CLR_ALL_TOT) |=> cmd_strobe.clr_all_tot ##1 !cmd_strobe.clr_all_tot)
        else $error("clear totals strobe wrong");
    // RQ21 - strobes only after a command write
    AST_NO_STRAY: assert property (@(posedge mclk) disable iff (srst) // RQ21
        (cmd_strobe != '0) |-> $past(is_write && req.addr == mbrd_pkg::REG_CMD))
        else $error("strobe without command write");
    // RQ22 - read-only write refused
    AST_RO_EXC: assert property (@(posedge mclk) disable iff (srst) // RQ22
        (is_write && port_unrestricted && req_count == 8'h01 && req.addr == mbrd_pkg::REG_SYS_BASE)
        |=> rsp.valid && rsp.exc == mbrd_pkg::EXC_ADDR)
        else $error("read-only write not refused");
    // RQ18 - restricted port refused
    AST_SECURE: assert property (@(posedge mclk) disable iff (srst) // RQ18
        (req.valid && !port_unrestricted) |=> rsp.exc == mbrd_pkg::EXC_DEVICE && cmd_strobe == '0)
        else $error("restricted port served");
    // RQ2 - float high word first
    AST_MSW: assert property (@(posedge mclk) disable iff (srst) // RQ2
        (is_read && port_unrestricted && req_count == 8'h01 && req.addr == mbrd_pkg::REG_FLOAT_BASE)
        |=> rsp.rdata == $past(flow_float[31:16]))
        else $error("float word order wrong");
    // RQ6 - empty name reads pad
    AST_PAD: assert property (@(posedge mclk) disable iff (srst) // RQ6
        (is_read && port_unrestricted && req_count == 8'h01 && name_len == 5'h00 &&
         req.addr == mbrd_pkg::REG_NAME_LAST) |=> rsp.rdata == 16'hffff)
        else $error("unused chars not padded");
    // RQ19 - other functions refused
    AST_FUNC: assert property (@(posedge mclk) disable iff (srst) // RQ19
        (req.valid && port_unrestricted && !is_read && !is_write) |=> rsp.exc == mbrd_pkg::EXC_FUNC)
        else $error("bad function accepted");
    // RQ15 - pulse count from argument register
    AST_PULSE: assert property (@(posedge mclk) disable iff (srst) // RQ15
        cmd_strobe.add_pulses |-> pulse_add_count == state_q.cmd_arg)
        else $error("pulse count mismatch");

    // RQ11 - rollover strobe
    AST_POLL_ROLL: assert property (s_cmd(mbrd_pkg::CMD_POLL_ROLL) // RQ11
        |=> cmd_strobe.poll_roll) else $error("rollover strobe missing");

    // RQ12 - run one totals strobe
    AST_CLR_RUN1: assert property (s_cmd(mbrd_pkg::CMD_CLR_RUN1_TOT) // RQ12
        |=> cmd_strobe.clr_run1_tot) else $error("run one clear missing");

    // RQ13 - first turbine strobe
    AST_CLR_TURB1: assert property (s_cmd(mbrd_pkg::CMD_CLR_TURB1) // RQ13
        |=> cmd_strobe.clr_turb1) else $error("turbine one clear missing");

    // RQ13 - second turbine strobe
    AST_CLR_TURB2: assert property (s_cmd(mbrd_pkg::CMD_CLR_TURB2) // RQ13
        |=> cmd_strobe.clr_turb2) else $error("turbine two clear missing");

    // RQ14 - all latches strobe
    AST_CLR_LATCHES: assert property (s_cmd(mbrd_pkg::CMD_CLR_ALL_LATCH) // RQ14
        |=> cmd_strobe.clr_all_latch) else $error("latch clear missing");

    // RQ14 - first latch strobe
    AST_CLR_LATCH1: assert property (s_cmd(mbrd_pkg::CMD_CLR_LATCH1) // RQ14
        |=> cmd_strobe.clr_latch1) else $error("latch one clear missing");

    // RQ15 - pulse add strobe
    AST_ADD_PULSES: assert property (s_cmd(mbrd_pkg::CMD_ADD_PULSES) // RQ15
        |=> cmd_strobe.add_pulses) else $error("pulse add strobe missing");

    // RQ16 - all alarms strobe
    AST_CLR_ALARMS: assert property (s_cmd(mbrd_pkg::CMD_CLR_ALL_ALARM) // RQ16
        |=> cmd_strobe.clr_all_alarm) else $error("alarm clear missing");

    // RQ16 - run alarm strobe
    AST_CLR_RUN_ALM: assert property (s_cmd(mbrd_pkg::CMD_CLR_RUN_ALARM) // RQ16
        |=> cmd_strobe.clr_run_alarm) else $error("run alarm clear missing");

    // RQ16 - input alarm strobe
    AST_CLR_IN_ALM: assert property (s_cmd(mbrd_pkg::CMD_CLR_IN_ALARM) // RQ16
        |=> cmd_strobe.clr_in_alarm) else $error("input alarm clear missing");

    // RQ17 - defaults strobe
    AST_DEFAULTS: assert property (s_cmd(mbrd_pkg::CMD_DEFAULTS) // RQ17
        |=> cmd_strobe.load_defaults) else $error("defaults strobe missing");

    // RQ17 - watchdog strobe
    AST_WATCHDOG: assert property (s_cmd(mbrd_pkg::CMD_WATCHDOG) // RQ17
        |=> cmd_strobe.watchdog_reset) else $error("watchdog strobe missing");

    // RQ17 - archive strobe
    AST_ARCHIVE: assert property (s_cmd(mbrd_pkg::CMD_PART_ARCHIVE) // RQ17
        |=> cmd_strobe.part_archive) else $error("archive strobe missing");

    // RQ10 - at most one function per write
    AST_ONE_STROBE: assert property ($onehot0(cmd_strobe)) // RQ10
        else $error("several strobes at once");

    // RQ15 - argument register stores
    AST_ARG_STORE: assert property (is_write && port_unrestricted && ok_count && // RQ15
        req.addr == mbrd_pkg::REG_CMD_ARG |=> state_q.cmd_arg == $past(req.wdata))
        else $error("argument register did not store");

    // RQ2 - long high word first
    AST_LONG_MSW: assert property (s_rd(mbrd_pkg::REG_LONG_BASE) // RQ2
        |=> rsp.rdata == $past(flow_long[31:16])) else $error("long word order wrong");

    // RQ1 - long low word second
    AST_LONG_LSW: assert property (s_rd(mbrd_pkg::REG_LONG_BASE + 16'h0001) // RQ1
        |=> rsp.rdata == $past(flow_long[15:0])) else $error("long low word wrong");

    // RQ1 - float low word second
    AST_FLOAT_LSW: assert property (s_rd(mbrd_pkg::REG_FLOAT_BASE + 16'h0001) // RQ1
        |=> rsp.rdata == $past(flow_float[15:0])) else $error("float low word wrong");

    // RQ8 - configuration block start
    AST_SYS_READ: assert property (s_rd(mbrd_pkg::REG_SYS_BASE) // RQ8
        |=> rsp.exc == mbrd_pkg::EXC_NONE && rsp.rdata == $past(sys_words[0]))
        else $error("configuration read wrong");

    // RQ5 - last name register holds chars 18 and 19
    AST_NAME_FULL: assert property (rd_ok && req.addr == mbrd_pkg::REG_NAME_LAST && // RQ5
        name_len == 5'd20 |=> rsp.rdata == $past({name_chars[18], name_chars[19]}))
        else $error("name tail wrong");

    // RQ4 - earlier char in high byte
    AST_NAME_HI: assert property (rd_ok && req.addr == mbrd_pkg::REG_NAME_BASE && // RQ4
        name_len == 5'd2 |=> rsp.rdata == $past({name_chars[0], name_chars[1]}))
        else $error("name byte order wrong");

    // RQ6 - odd length pads low byte
    AST_NAME_ODD: assert property (rd_ok && req.addr == mbrd_pkg::REG_NAME_BASE && // RQ6
        name_len == 5'd1 |=> rsp.rdata[7:0] == mbrd_pkg::PAD_CHAR)
        else $error("odd name not padded");

    // RQ7 - every access answered
    AST_ANSWER: assert property (req.valid |=> rsp.valid) // RQ7
        else $error("access not answered");

    // RQ21 - idle bus stays quiet
    AST_IDLE: assert property (!req.valid |=> !rsp.valid && cmd_strobe == '0) // RQ21
        else $error("answer without access");

    // RQ20 - bad counts refused, nothing fires
    AST_COUNT: assert property (port_unrestricted && (is_read || is_write) && // RQ20
        !ok_count |=> rsp.exc == mbrd_pkg::EXC_ADDR && cmd_strobe == '0)
        else $error("bad count accepted");

    // RQ18 - refused write keeps control register
    AST_CMD_KEEP: assert property (req.valid && !port_unrestricted // RQ18
        |=> state_q.cmd == $past(state_q.cmd)) else $error("refused write stored");
endmodule
`default_nettype wire

// File: tb/mbrd_master_model.sv
/*
 polling master model: issues one register access at a time.
 assumes the decoder answers with a one-cycle rsp.valid pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module mbrd_master_model (
    input wire logic mclk,
    output mbrd_pkg::mbrd_req_t req,
    output logic [7:0] req_count,
    input wire mbrd_pkg::mbrd_rsp_t rsp
);
    // bus idle at time zero
    initial begin
        req = '0;
        req_count = 8'h01;
    end
    // read 03h write 10h, direct address
    task automatic access(input logic [7:0] fc, input logic [15:0] a,
        input logic [15:0] wd, input logic [7:0] n,
        output logic [15:0] rd, output logic [7:0] ex);
        ex = 8'hee;
        rd = 16'h0000;
        @(negedge mclk);
        req <= {1'b1, fc, a, wd};
        req_count <= n;
        // bounded wait for the answer pulse
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            // released lines show inverted values
            req <= {1'b0, ~fc, ~a, ~wd};
            if (rsp.valid === 1'b1) begin
                rd = rsp.rdata;
                ex = rsp.exc;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: tb/mbrd_decoder_test.sv
/*
 bench for the register-map decoder: random sources, command table,
 refusals. assumes the master model drives the request port.
*/
`timescale 1ns/1ps
`default_nettype none
module mbrd_decoder_test;
    logic mclk = 1'b0; // system clock
    logic srst = 1'b1; // sync reset
    logic port_unrestricted = 1'b1; // default security
    logic [15:0] sys_words [0:17]; // config sources
    logic [7:0] name_chars [0:19]; // name sources
    logic [4:0] name_len = 5'h00; // valid chars
    logic [31:0] flow_float = 32'h0; // float source
    logic [31:0] flow_long = 32'h0; // long source
    mbrd_pkg::mbrd_req_t req; // request
    logic [7:0] req_count; // message size
    mbrd_pkg::mbrd_rsp_t rsp; // answer
    mbrd_pkg::mbrd_cmd_t cmd_strobe; // function strobes
    logic [15:0] pulse_add_count; // latched count
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'd31047; // xorshift state
    logic [15:0] rd; // read data
    logic [7:0] ex; // exception code
    logic [31:0] v; // scratch
    logic [15:0] codes [0:13] = '{mbrd_pkg::CMD_POLL_ROLL,
        mbrd_pkg::CMD_CLR_ALL_TOT, mbrd_pkg::CMD_CLR_RUN1_TOT,
        mbrd_pkg::CMD_CLR_TURB1, mbrd_pkg::CMD_CLR_TURB2,
        mbrd_pkg::CMD_CLR_ALL_LATCH, mbrd_pkg::CMD_CLR_LATCH1,
        mbrd_pkg::CMD_ADD_PULSES, mbrd_pkg::CMD_CLR_ALL_ALARM,
        mbrd_pkg::CMD_CLR_RUN_ALARM, mbrd_pkg::CMD_CLR_IN_ALARM,
        mbrd_pkg::CMD_DEFAULTS, mbrd_pkg::CMD_WATCHDOG,
        mbrd_pkg::CMD_PART_ARCHIVE}; // strobe order
    // clock
    always #2 mclk = ~mclk;
    mbrd_decoder i_dut (.mclk(mclk), .srst(srst), .req(req), .req_count(req_count),
        .port_unrestricted(port_unrestricted), .sys_words(sys_words),
        .name_chars(name_chars), .name_len(name_len), .flow_float(flow_float),
        .flow_long(flow_long), .rsp(rsp), .cmd_strobe(cmd_strobe),
        .pulse_add_count(pulse_add_count));
    mbrd_master_model i_master (.mclk(mclk), .req(req), .req_count(req_count),
        .rsp(rsp));
    // random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected name register k
    function automatic logic [15:0] name_exp(int k);
        logic [7:0] h;
        logic [7:0] l;
        h = (2 * k < name_len) ? name_chars[2 * k] : 8'hff;
        l = (2 * k + 1 < name_len) ? name_chars[2 * k + 1] : 8'hff;
        return {h, l};
    endfunction
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one access, a lost answer ends the run
    task automatic acc(input logic [7:0] fc, input logic [15:0] a,
        input logic [15:0] wd, input logic [7:0] n);
        i_master.access(fc, a, wd, n, rd, ex);
        if (ex === 8'hee) begin
            bad_count++;
            end_of_test();
        end
    endtask
    // main sequence
    initial begin
        for (int k = 0; k < 18; k++) sys_words[k] = 16'h0000;
        for (int k = 0; k < 20; k++) name_chars[k] = 8'h00;
        repeat (20) @(posedge mclk);
        @(negedge mclk) srst = 1'b0;
        check(rsp, 32'h0);
        check(cmd_strobe, 32'h0);
        check(pulse_add_count, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 14; i++) begin
            acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_CMD, codes[i], 8'h01);
            check(cmd_strobe, 14'h2000 >> i);
            acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_CMD, 16'h0, 8'h01);
            check(rd, codes[i]);
            check(cmd_strobe, 32'h0);
        end
        acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_CMD, 16'd30002, 8'h01);
        check(cmd_strobe, 32'h0);
        $display("command test done");
        // pulse count from second control register
        v = xs();
        acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_CMD_ARG, v[15:0], 8'h7d);
        acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_CMD, mbrd_pkg::CMD_ADD_PULSES, 8'h01);
        check(cmd_strobe, 14'h0040);
        check(pulse_add_count, v[15:0]);
        $display("pulse test done");
        for (int t = 0; t < 4; t++) begin
            for (int k = 0; k < 18; k++) sys_words[k] = 16'(xs());
            for (int k = 0; k < 20; k++) name_chars[k] = 8'(xs());
            name_len = (t == 0) ? 5'd0 : (t == 1) ? 5'd20 : 5'(xs() % 21);
            flow_float = xs();
            flow_long = xs();
            for (int k = 0; k < 18; k++) begin
                acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_SYS_BASE + 16'(k), 16'h0, 8'h01);
                check(rd, sys_words[k]);
            end
            for (int k = 0; k < 10; k++) begin
                acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_NAME_BASE + 16'(k), 16'h0, 8'h0a);
                check(rd, name_exp(k));
            end
            for (int k = 0; k < 4; k++) begin
                v = (k < 2) ? flow_float : flow_long;
                acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_FLOAT_BASE + 16'(k), 16'h0, 8'h04);
                check(rd, (k % 2) ? v[15:0] : v[31:16]);
            end
        end
        $display("format test done");
        acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_SYS_BASE, ~sys_words[0], 8'h01);
        check(ex, mbrd_pkg::EXC_ADDR);
        acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_SYS_BASE, 16'h0, 8'h01);
        check(rd, sys_words[0]);
        acc(8'h05, mbrd_pkg::REG_CMD, 16'h0, 8'h01);
        check(ex, mbrd_pkg::EXC_FUNC);
        acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_CMD, mbrd_pkg::CMD_CLR_ALL_TOT, 8'h00);
        check(ex, mbrd_pkg::EXC_ADDR);
        check(cmd_strobe, 32'h0);
        acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_CMD, 16'h0, 8'h7e);
        check(ex, mbrd_pkg::EXC_ADDR);
        acc(mbrd_pkg::FC_READ, 16'h0000, 16'h0, 8'h01);
        check(ex, mbrd_pkg::EXC_ADDR);
        port_unrestricted = 1'b0;
        acc(mbrd_pkg::FC_WRITE, mbrd_pkg::REG_CMD, mbrd_pkg::CMD_WATCHDOG, 8'h01);
        check(ex, mbrd_pkg::EXC_DEVICE);
        check(cmd_strobe, 32'h0);
        port_unrestricted = 1'b1;
        acc(mbrd_pkg::FC_READ, mbrd_pkg::REG_CMD, 16'h0, 8'h01);
        check(rd, mbrd_pkg::CMD_ADD_PULSES);
        $display("refusal test done");
        end_of_test();
    end
endmodule
`default_nettype wire
